// ---- uwpp_top.sv ----
/*
  Serial transmitter/receiver plus one 8-bit parallel port behind a byte-wide
  host port (data buffer, command buffer, status byte).
  Assumes a free-running 76.8 kHz reference and asynchronous rxd and parallel
  pins; all three pass a three-stage synchroniser.
*/
// The implementer's own choices: the address map and the plain strobed port.
`default_nettype none
module uwpp_top (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic rxd_i,
  input wire logic ref_clk_i,
  output logic txd_o,
  output logic tx_empty_o,
  output logic data_avail_o,
  output logic tick_o,
  input wire logic [7:0] par_i,
  output logic [7:0] par_o,
  output logic par_oe_n_o
);
  // Synchronisers: only stage two reads stage one
  logic rx_s1_q, rx_s2_q, rx_s3_q, rx_lvl_q;
  logic ref_s1_q, ref_s2_q, ref_s3_q, ref_lvl_q;
  logic [7:0] par_s1_q, par_s2_q, par_s3_q, par_lvl_q;

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      {rx_s1_q, rx_s2_q, rx_s3_q, rx_lvl_q} <= 4'hF;
      {ref_s1_q, ref_s2_q, ref_s3_q, ref_lvl_q} <= 4'h0;
    end else begin
      {rx_s1_q, rx_s2_q, rx_s3_q} <= {rxd_i, rx_s1_q, rx_s2_q};
      {ref_s1_q, ref_s2_q, ref_s3_q} <= {ref_clk_i, ref_s1_q, ref_s2_q};
      if (rx_s2_q == rx_s3_q) rx_lvl_q <= rx_s3_q;
      if (ref_s2_q == ref_s3_q) ref_lvl_q <= ref_s3_q;
    end
  end

  wire [7:0] par_agree = ~(par_s2_q ^ par_s3_q);
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      par_s1_q <= uwpp_pkg::BYTE_RST;
      par_s2_q <= uwpp_pkg::BYTE_RST;
      par_s3_q <= uwpp_pkg::BYTE_RST;
      par_lvl_q <= uwpp_pkg::BYTE_RST;
    end else begin
      par_s1_q <= par_i;
      par_s2_q <= par_s1_q;
      par_s3_q <= par_s2_q;
      par_lvl_q <= (par_s3_q & par_agree) | (par_lvl_q & ~par_agree);
    end
  end

  // Host port decode
  logic obf_q, ibf_q, dir_in_q, io_pend_q, run_q, txe_q, frm_q, ovr_q, rx_rdy_q;
  logic [1:0] src_q;
  logic [7:0] obuf_q, div_q, div_cnt_q, rdata_q;
  wire [1:0] cmd_op = wdata_i[uwpp_pkg::CMD_OP_HI:uwpp_pkg::CMD_OP_LO];
  wire [1:0] cmd_rate = wdata_i[uwpp_pkg::CMD_RATE_HI:uwpp_pkg::CMD_RATE_LO];
  wire wr_data = wr_i && (addr_i == uwpp_pkg::ADDR_DATA);
  wire wr_cmd = wr_i && (addr_i == uwpp_pkg::ADDR_CMD);
  wire rd_data = rd_i && (addr_i == uwpp_pkg::ADDR_DATA);
  wire setup_ev = wr_cmd && (cmd_op == uwpp_pkg::CMD_SETUP);
  wire xfer_ev = wr_cmd && (cmd_op == uwpp_pkg::CMD_XFER);
  wire clr_ev = wr_cmd && (cmd_op == uwpp_pkg::CMD_CLRERR);
  wire port_wr = wr_data && io_pend_q && !dir_in_q;
  wire tx_wr = wr_data && !port_wr;
  wire load_rx = !obf_q && rx_rdy_q;
  wire load_par = !obf_q && !rx_rdy_q && io_pend_q && dir_in_q;
  wire [7:0] status = {ovr_q, frm_q, txe_q, 1'b0, src_q, ibf_q, obf_q};
  wire [7:0] rdata_d = !rd_i ? uwpp_pkg::BYTE_RST : (rd_data ? obuf_q : status);
  wire [7:0] rate_div = (cmd_rate == uwpp_pkg::RATE_110) ? uwpp_pkg::DIV_110 :
                        (cmd_rate == uwpp_pkg::RATE_300) ? uwpp_pkg::DIV_300 :
                        (cmd_rate == uwpp_pkg::RATE_600) ? uwpp_pkg::DIV_600 :
                        uwpp_pkg::DIV_1200;

  // Tick generator: falling reference edges counted down to one
  // Counting edges, not clocks, keeps the tick period independent of mclk_i
  wire ref_fall = (ref_s2_q == ref_s3_q) && !ref_s3_q && ref_lvl_q;
  wire tick_ev = run_q && ref_fall && (div_cnt_q == 8'h01);
  logic tick_q;

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      run_q <= 1'b0;
      div_q <= uwpp_pkg::DIV_RST;
      div_cnt_q <= uwpp_pkg::DIV_RST;
      tick_q <= 1'b0;
    end else begin
      tick_q <= tick_ev;
      if (setup_ev) begin
        run_q <= 1'b1;
        div_q <= rate_div;
        div_cnt_q <= rate_div;
      end else if (tick_ev) begin
        div_cnt_q <= div_q;
      end else if (run_q && ref_fall) begin
        div_cnt_q <= div_cnt_q - 8'h01;
      end
    end
  end

  // Receiver
  logic rx_busy_q, rx_good_q, rx_bdone_q;
  logic [2:0] rx_cnt_q;
  logic [7:0] rx_sh_q, rx_hold_q;
  logic rx_busy_d, rx_good_d, rx_bdone_d;
  logic [2:0] rx_cnt_d;
  logic [7:0] rx_sh_d;
  wire rx_sample = tick_ev && rx_busy_q && rx_good_q && (rx_cnt_q == 3'h1);
  wire rx_done = rx_sample && rx_bdone_q;

  always_comb begin
    rx_busy_d = rx_busy_q;
    rx_good_d = rx_good_q;
    rx_bdone_d = rx_bdone_q;
    rx_cnt_d = rx_cnt_q;
    rx_sh_d = rx_sh_q;
    if (tick_ev) begin
      if (!rx_busy_q) begin
        rx_busy_d = !rx_lvl_q;
      end else if (!rx_good_q) begin
        if (rx_lvl_q) begin
          rx_busy_d = 1'b0;
        end else begin
          rx_good_d = 1'b1;
          rx_cnt_d = uwpp_pkg::RX_TICKS;
          rx_sh_d = uwpp_pkg::RX_PRESET;
        end
      end else if (rx_cnt_q != 3'h1) begin
        rx_cnt_d = rx_cnt_q - 3'h1;
      end else begin
        rx_cnt_d = uwpp_pkg::RX_TICKS;
        if (!rx_bdone_q) begin
          rx_sh_d = {rx_lvl_q, rx_sh_q[7:1]};
          rx_bdone_d = rx_sh_q[0];
        end else begin
          rx_busy_d = 1'b0;
          rx_good_d = 1'b0;
          rx_bdone_d = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      {rx_busy_q, rx_good_q, rx_bdone_q} <= 3'h0;
      rx_cnt_q <= uwpp_pkg::RX_TICKS;
      rx_sh_q <= uwpp_pkg::BYTE_RST;
      rx_hold_q <= uwpp_pkg::BYTE_RST;
      rx_rdy_q <= 1'b0;
    end else begin
      {rx_busy_q, rx_good_q, rx_bdone_q} <= {rx_busy_d, rx_good_d, rx_bdone_d};
      rx_cnt_q <= rx_cnt_d;
      rx_sh_q <= rx_sh_d;
      if (rx_done) rx_hold_q <= rx_sh_q;
      if (rx_done) rx_rdy_q <= 1'b1;
      else if (load_rx) rx_rdy_q <= 1'b0;
    end
  end

  // Error flags: set wins over the clear command
  // A character finishing while the held one moves out is not an overrun
  wire frm_set = rx_done && !rx_lvl_q;
  wire ovr_set = rx_done && rx_rdy_q && !load_rx;
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      frm_q <= 1'b0;
      ovr_q <= 1'b0;
    end else begin
      frm_q <= frm_set || (frm_q && !clr_ev);
      ovr_q <= ovr_set || (ovr_q && !clr_ev);
    end
  end

  // Host buffers and parallel port
  logic [7:0] par_out_q;
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      obf_q <= 1'b0;
      ibf_q <= 1'b0;
      src_q <= uwpp_pkg::SRC_NONE;
      obuf_q <= uwpp_pkg::BYTE_RST;
      rdata_q <= uwpp_pkg::BYTE_RST;
      dir_in_q <= 1'b1;
      io_pend_q <= 1'b0;
      par_out_q <= uwpp_pkg::PAR_OUT_RST;
      par_oe_n_o <= 1'b1;
    end else begin
      ibf_q <= wr_i;
      rdata_q <= rdata_d;
      par_oe_n_o <= dir_in_q;
      if (load_rx || load_par) begin
        obf_q <= 1'b1;
        obuf_q <= load_rx ? rx_hold_q : par_lvl_q;
        src_q <= load_rx ? uwpp_pkg::SRC_RX : uwpp_pkg::SRC_PAR;
      end else if (rd_data) begin
        obf_q <= 1'b0;
      end
      if (setup_ev) begin
        dir_in_q <= wdata_i[uwpp_pkg::CMD_DIR_BIT];
        io_pend_q <= 1'b0;
        if (wdata_i[uwpp_pkg::CMD_DIR_BIT]) par_out_q <= uwpp_pkg::PAR_OUT_RST;
      end else if (xfer_ev) begin
        io_pend_q <= 1'b1;
      end else if (port_wr || load_par) begin
        io_pend_q <= 1'b0;
      end
      if (port_wr) par_out_q <= wdata_i;
    end
  end

  // Transmitter: level prepared in tx_pipe_q, driven out on the next tick
  // Limitation: back-to-back characters get a longer stop, as idle waits a fourth tick
  logic tx_pipe_q, txd_q, tx_sflag_q, tx_act_q, tx_req_q;
  logic [5:0] tx_cnt_q;
  logic [7:0] tx_sh_q, tx_hold_q;
  logic tx_pipe_d, tx_sflag_d, tx_act_d, tx_req_d, txe_d;
  logic [5:0] tx_cnt_d;
  logic [7:0] tx_sh_d;
  wire [5:0] tx_cnt_inc = tx_cnt_q + 6'h01;

  always_comb begin
    tx_pipe_d = tx_pipe_q;
    tx_sflag_d = tx_sflag_q;
    tx_act_d = tx_act_q;
    tx_req_d = tx_req_q;
    tx_cnt_d = tx_cnt_q;
    tx_sh_d = tx_sh_q;
    txe_d = txe_q;
    if (tick_ev) begin
      if (tx_sflag_q) begin
        tx_sflag_d = 1'b0;
        tx_cnt_d = uwpp_pkg::TX_CNT_START;
      end else begin
        tx_cnt_d = tx_cnt_inc;
        if (tx_cnt_inc[1:0] == 2'h0) begin
          if (!tx_act_q) begin
            txe_d = 1'b1;
            if (tx_req_q) begin
              tx_sh_d = tx_hold_q;
              tx_req_d = 1'b0;
              tx_act_d = 1'b1;
              tx_sflag_d = 1'b1;
              tx_pipe_d = 1'b0;
            end
          end else if (tx_cnt_inc == uwpp_pkg::TX_DONE) begin
            tx_act_d = 1'b0;
          end else if (tx_cnt_inc == uwpp_pkg::TX_DATA_END) begin
            tx_pipe_d = 1'b1;
          end else begin
            tx_pipe_d = tx_sh_q[0];
            tx_sh_d = {1'b0, tx_sh_q[7:1]};
          end
        end
      end
    end
    if (tx_wr) begin
      tx_req_d = 1'b1;
      txe_d = 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      {tx_pipe_q, txd_q} <= 2'h3;
      {tx_sflag_q, tx_act_q, tx_req_q} <= 3'h0;
      txe_q <= 1'b1;
      tx_cnt_q <= 6'h00;
      tx_sh_q <= uwpp_pkg::BYTE_RST;
      tx_hold_q <= uwpp_pkg::BYTE_RST;
    end else begin
      if (tick_ev) txd_q <= tx_pipe_q;
      {tx_pipe_q, tx_sflag_q, tx_act_q, tx_req_q, txe_q} <= {tx_pipe_d, tx_sflag_d, tx_act_d, tx_req_d, txe_d};
      tx_cnt_q <= tx_cnt_d;
      tx_sh_q <= tx_sh_d;
      if (tx_wr) tx_hold_q <= wdata_i;
    end
  end

  assign rdata_o = rdata_q;
  assign txd_o = txd_q;
  assign tx_empty_o = txe_q;
  assign data_avail_o = obf_q;
  assign tick_o = tick_q;
  assign par_o = par_out_q;

  // Checks
  obf_read_clr_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (rd_data && obf_q) |=> !obf_q && !data_avail_o)
    else $error("data-available flag not cleared by buffer read");

  txe_write_clr_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    tx_wr |=> !tx_empty_o && tx_req_q)
    else $error("transmit empty flag not cleared by data write");

  err_clear_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (clr_ev && !rx_done) |=> !frm_q && !ovr_q)
    else $error("error flags survived the clear command");

  overrun_set_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (rx_done && rx_rdy_q && !load_rx) |=> ovr_q && rx_hold_q == $past(rx_sh_q))
    else $error("overrun not flagged or character not replaced");

  txd_pipe_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    tick_ev |=> txd_o == $past(tx_pipe_q) ##1 $stable(txd_o))
    else $error("serial output not taken from prepared level");

  start_preset_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (tick_ev && rx_busy_q && !rx_good_q && !rx_lvl_q) |=> rx_good_q && rx_sh_q == 8'h80 && rx_cnt_q == 3'h4)
    else $error("receive shift register not preset on good start");

  start_abort_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (tick_ev && rx_busy_q && !rx_good_q && rx_lvl_q) |=> !rx_busy_q && !rx_good_q)
    else $error("false start bit not abandoned");

  par_sample_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    load_par |=> obf_q && obuf_q == $past(par_lvl_q) && src_q == 2'h2 && !io_pend_q)
    else $error("parallel sample not placed in output buffer");

  div_reload_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (tick_ev && !setup_ev) |=> div_cnt_q == $past(div_q) && tick_o)
    else $error("edge counter not reloaded on tick");

  tick_pulse_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    tick_o |=> !tick_o)
    else $error("diagnostic tick longer than one cycle");

  err_sticky_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    !clr_ev |=> (frm_q || !$past(frm_q)) && (ovr_q || !$past(ovr_q)))
    else $error("error flag dropped without clear command");

  rx_hold_wait_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (rx_rdy_q && obf_q) |=> rx_rdy_q)
    else $error("held character left while output buffer full");

  port_write_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    port_wr |=> par_o == $past(wdata_i) && !io_pend_q)
    else $error("output port byte not latched");
endmodule
`default_nettype wire

// ---- uwpp_pkg.sv ----
/*
  Constants shared by the serial and parallel combination port: host port
  addresses, command layout, status bit positions, divisors and reset values.
  Assumes a 76.8 kHz bit-rate reference and four ticks per serial bit.
*/
`default_nettype none
package uwpp_pkg;
  // Host port addresses
  localparam logic ADDR_DATA = 1'b0;
  localparam logic ADDR_CMD = 1'b1;

  // Command byte layout
  localparam int CMD_OP_HI = 7;
  localparam int CMD_OP_LO = 6;
  localparam int CMD_DIR_BIT = 2;
  localparam int CMD_RATE_HI = 1;
  localparam int CMD_RATE_LO = 0;
  localparam logic [1:0] CMD_SETUP = 2'h0;
  localparam logic [1:0] CMD_XFER = 2'h1;
  localparam logic [1:0] CMD_CLRERR = 2'h2;

  // Rate select codes
  localparam logic [1:0] RATE_110 = 2'h0;
  localparam logic [1:0] RATE_300 = 2'h1;
  localparam logic [1:0] RATE_600 = 2'h2;
  localparam logic [1:0] RATE_1200 = 2'h3;

  // Bit-rate reference and tick divisors, rounded to nearest edge count
  localparam int REF_HZ = 76800;
  localparam int TICKS_PER_BIT = 4;
  localparam logic [7:0] DIV_110 = 8'((REF_HZ + TICKS_PER_BIT * 110 / 2) / (TICKS_PER_BIT * 110));
  localparam logic [7:0] DIV_300 = 8'((REF_HZ + TICKS_PER_BIT * 300 / 2) / (TICKS_PER_BIT * 300));
  localparam logic [7:0] DIV_600 = 8'((REF_HZ + TICKS_PER_BIT * 600 / 2) / (TICKS_PER_BIT * 600));
  localparam logic [7:0] DIV_1200 = 8'((REF_HZ + TICKS_PER_BIT * 1200 / 2) / (TICKS_PER_BIT * 1200));
  localparam logic [7:0] DIV_RST = 8'h01;

  // Host status byte bit positions
  localparam int ST_OBF = 0;
  localparam int ST_IBF = 1;
  localparam int ST_SRC_LO = 2;
  localparam int ST_SRC_HI = 3;
  localparam int ST_TXE = 5;
  localparam int ST_FRM = 6;
  localparam int ST_OVR = 7;

  // Output buffer source codes, {source_code_high, source_code_low}
  localparam logic [1:0] SRC_NONE = 2'h0;
  localparam logic [1:0] SRC_RX = 2'h1;
  localparam logic [1:0] SRC_PAR = 2'h2;

  // Receiver and transmitter sequencing
  localparam logic [7:0] RX_PRESET = 8'h80;
  localparam logic [2:0] RX_TICKS = 3'h4;
  localparam logic [5:0] TX_CNT_START = 6'h01;
  localparam logic [5:0] TX_DATA_END = 6'h24;
  localparam logic [5:0] TX_DONE = 6'h28;

  // Reset values
  localparam logic [7:0] PAR_OUT_RST = 8'hFF;
  localparam logic [7:0] BYTE_RST = 8'h00;
endpackage
`default_nettype wire

// ---- uwpp_far_end.sv ----
/*
  Far-end model of the combination port: bit-rate reference source and a
  serial sender that frames one character per request onto the receive line.
  Assumes the bench raises send_i for one clock and holds char_i until busy_o falls.
*/
`default_nettype none
module uwpp_far_end #(
  parameter int REF_HALF_NS = 510,
  parameter int BIT_NS = 65280
) (
  input wire logic send_i,
  input wire logic [7:0] char_i,
  input wire logic bad_stop_i,
  output logic rxd_o,
  output logic ref_o,
  output logic busy_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    ref_o = 1'b0;
    rxd_o = 1'b1;
    busy_o = 1'b0;
  end
  // Reference is faster than the real one to keep the run short; period is not a clock multiple
  always #(REF_HALF_NS) ref_o = ~ref_o;
  always @(posedge send_i) begin
    busy_o = 1'b1;
    rxd_o = 1'b0;
    #(BIT_NS);
    for (int i = 0; i < 8; i++) begin
      rxd_o = char_i[i];
      #(BIT_NS);
    end
    rxd_o = ~bad_stop_i;
    // A broken stop ends a quarter bit early, so the line is idle before the next start
    #(BIT_NS * 3 / 4);
    rxd_o = 1'b1;
    #(BIT_NS - BIT_NS * 3 / 4);
    busy_o = 1'b0;
  end
endmodule
`default_nettype wire

// ---- test_uwpp_top.sv ----
/*
  Self-checking bench for the serial and parallel combination port.
  Assumes the far-end model drives the reference and the receive line.
*/
`default_nettype none
module test_uwpp_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int REF_HALF = 510;
  localparam int BIT_NS = 65280;
  logic mclk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic addr_i = 1'b0;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [7:0] par_i = 8'h00;
  logic send = 1'b0;
  logic bad_stop = 1'b0;
  logic [7:0] sch = 8'h00;
  wire logic rxd, ref_clk, far_busy, txd_o, tx_empty_o, data_avail_o, tick_o, par_oe_n_o;
  wire logic [7:0] rdata_o, par_o;
  int n_errors = 0;
  int cmp_count = 0;
  int seed = 32'h35C1;
  int cyc = 0;
  int t0, t1;
  logic [7:0] d, st, c1, c3;
  always #50 mclk_i = ~mclk_i;
  always @(posedge mclk_i) cyc <= cyc + 1;
  uwpp_top dut (.mclk_i(mclk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .rxd_i(rxd), .ref_clk_i(ref_clk), .txd_o(txd_o),
    .tx_empty_o(tx_empty_o), .data_avail_o(data_avail_o), .tick_o(tick_o), .par_i(par_i),
    .par_o(par_o), .par_oe_n_o(par_oe_n_o));
  uwpp_far_end #(.REF_HALF_NS(REF_HALF), .BIT_NS(BIT_NS)) far (.send_i(send), .char_i(sch),
    .bad_stop_i(bad_stop), .rxd_o(rxd), .ref_o(ref_clk), .busy_o(far_busy));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Writes leave one idle cycle behind them for the busy bit
  task automatic bus_wr(input logic a, input logic [7:0] v);
    @(posedge mclk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask
  task automatic bus_rd(input logic a, output logic [7:0] v);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1;
    v = rdata_o;
  endtask
  task automatic next_tick(output int t);
    t = 0;
    for (int k = 0; k < 4000; k++) begin
      @(posedge mclk_i);
      #1;
      if (tick_o === 1'b1) begin
        t = cyc;
        break;
      end
    end
  endtask
  task automatic rx_char(input logic [7:0] c, input logic bad);
    @(posedge mclk_i);
    sch <= c;
    bad_stop <= bad;
    send <= 1'b1;
    @(posedge mclk_i);
    send <= 1'b0;
    wait (far_busy === 1'b0);
    repeat (20) @(posedge mclk_i);
  endtask
  function automatic int exp_div(input int r);
    int b;
    b = (r == 0) ? 110 : 300 * (1 << (r - 1));
    return (76800 + 2 * b) / (4 * b);
  endfunction
  function automatic logic in_tol(input int seen_ns, input int exp_ns, input int tol_ns);
    return (seen_ns >= exp_ns - tol_ns) && (seen_ns <= exp_ns + tol_ns);
  endfunction
  function automatic logic frame_bit(input logic [7:0] c, input int i);
    return (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : c[i - 1];
  endfunction
  initial begin
    #8_000_000;
    n_errors++;
    test_done();
  end
  initial begin
    par_i = 8'($random(seed));
    repeat (10) @(posedge mclk_i);
    rstn_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    check(rdata_o, 8'h00);
    check({txd_o, tx_empty_o, data_avail_o, tick_o, par_oe_n_o}, 8'h19);
    check(par_o, 8'hFF);
    // Busy shows in the cycle right after a write; an unknown op changes nothing
    bus_rd(1'b1, st);
    addr_i <= 1'b1;
    wdata_i <= 8'hC0;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1;
    check(rdata_o & 8'h02, 8'h02);
    check(rdata_o & 8'hFD, st);
    for (int r = 0; r < 4; r++) begin
      bus_wr(1'b1, 8'(r));
      next_tick(t0);
      next_tick(t0);
      next_tick(t1);
      check(8'(in_tol((t1 - t0) * 100, exp_div(r) * 2 * REF_HALF, 300)), 8'h01);
    end
    check(8'(par_oe_n_o), 8'h00);
    d = 8'($random(seed));
    bus_wr(1'b1, 8'h40);
    bus_wr(1'b0, d);
    repeat (2) @(posedge mclk_i);
    check(par_o, d);
    d = 8'($random(seed));
    bus_wr(1'b0, d);
    #1;
    check(8'(tx_empty_o), 8'h00);
    for (int k = 0; k < 3000 && txd_o === 1'b1; k++) @(posedge mclk_i);
    #(BIT_NS / 2);
    for (int i = 0; i < 10; i++) begin
      check(8'(txd_o), 8'(frame_bit(d, i)));
      #(BIT_NS);
    end
    check(8'(tx_empty_o), 8'h01);
    d = 8'($random(seed));
    rx_char(d, 1'b0);
    check(8'(data_avail_o), 8'h01);
    bus_rd(1'b1, st);
    check(st, 8'h25);
    bus_rd(1'b0, st);
    check(st, d);
    check(8'(data_avail_o), 8'h00);
    // Framing error, then a held character overrun by a third one
    c1 = 8'($random(seed));
    c3 = 8'($random(seed));
    rx_char(c1, 1'b1);
    rx_char(8'($random(seed)), 1'b0);
    rx_char(c3, 1'b0);
    bus_rd(1'b0, st);
    check(st, c1);
    repeat (4) @(posedge mclk_i);
    bus_rd(1'b1, st);
    check(st, 8'hE5);
    bus_rd(1'b0, st);
    check(st, c3);
    bus_wr(1'b1, 8'h80);
    bus_rd(1'b1, st);
    check(st, 8'h24);
    bus_wr(1'b1, 8'h07);
    repeat (2) @(posedge mclk_i);
    check({par_o[6:0], par_oe_n_o}, 8'hFF);
    bus_wr(1'b1, 8'h40);
    for (int k = 0; k < 200 && data_avail_o !== 1'b1; k++) @(posedge mclk_i);
    bus_rd(1'b1, st);
    check(st, 8'h29);
    bus_rd(1'b0, st);
    check(st, par_i);
    test_done();
  end
endmodule
`default_nettype wire
